// file: verilog/lvl_link_map.vh
// Constants shared by the serial link transmitter and receiver
`ifndef LVL_LINK_MAP_VH
`define LVL_LINK_MAP_VH

// Word and lane geometry: bit (lane * slots + slot) of the parallel word
`define LVL_WORD_BITS      28
`define LVL_LANES          4
`define LVL_SLOTS          7
`define LVL_SLOT_LAST      3'h6
`define LVL_SLOT_FIRST     3'h0

// Fraction step: slots per parallel period, added every system clock
`define LVL_SLOT_STEP      9'h007

// Forwarded clock level per slot, bit i for slot i: high for slots 0-3
`define LVL_FWD_PATTERN    7'h0f

// Period measurement (system clocks per parallel clock) and its reset value
`define LVL_PERIOD_RST     8'h08
`define LVL_PERIOD_MAX     8'hff

// Timing
`define LVL_CLK_PERIOD_NS  100
`define LVL_PLL_LOCK_MS    10
`define LVL_PD_DELAY_NS    100

`endif

// file: verilog/lvl_sync.v
// Two-stage synchroniser for a group of asynchronous level inputs
`timescale 1ns/10ps

module lvl_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk_i,
  input  wire             srst_i,
  input  wire [WIDTH-1:0] d_i,
  output reg  [WIDTH-1:0] q_o
);

  reg [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always @(posedge clk_i) begin
    if (srst_i) begin
      meta <= {WIDTH{1'b0}};
      q_o  <= {WIDTH{1'b0}};
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule // lvl_sync

// file: verilog/lvl_rx.v
// Receive half: slot recovery from the forwarded clock and word rebuild
`timescale 1ns/10ps
`include "lvl_link_map.vh"

module lvl_rx (
  input  wire                       clk_i,
  input  wire                       srst_i,
  input  wire                       pd_n_i,
  input  wire                       fwd_clk_i,
  input  wire [`LVL_LANES-1:0]      lane_i,
  output reg  [`LVL_WORD_BITS-1:0]  data_o,
  output reg                        rclk_o
);

  reg                        fwd_q;
  reg [7:0]                  per_cnt;
  reg [7:0]                  period;
  reg [7:0]                  acc;
  reg [2:0]                  slot;
  reg                        seen;
  reg                        pub_d;
  reg [`LVL_WORD_BITS-1:0]   asm_word;
  reg [`LVL_WORD_BITS-1:0]   next_asm;
  reg [7:0]                  next_acc;
  reg [2:0]                  next_slot;
  reg [8:0]                  step;
  integer                    l;

  wire fwd_rise = fwd_clk_i & ~fwd_q;   // Frame starts at forwarded clock rise
  wire publish  = fwd_rise & seen;      // A full frame has been gathered

  // Slot tracking mirrors the transmitter's fraction stepping [R3]
  always @* begin
    step      = {1'b0, acc} + `LVL_SLOT_STEP;
    next_acc  = acc;
    next_slot = slot;
    next_asm  = asm_word;
    if (fwd_rise) begin
      next_slot = `LVL_SLOT_FIRST;
      next_acc  = 8'h00;
    end else if (slot != `LVL_SLOT_LAST) begin
      if (step >= {1'b0, period}) begin
        next_slot = slot + 3'h1;
        next_acc  = step[7:0] - period;
      end else begin
        next_acc = step[7:0];
      end
    end
    // Last sample inside a slot wins; lane l slot s holds bit l*7+s [R13] [R4]
    for (l = 0; l < `LVL_LANES; l = l + 1) begin
      next_asm[l*`LVL_SLOTS + next_slot] = lane_i[l];
    end
  end

  // Frame state, period measurement and outputs
  always @(posedge clk_i) begin
    if (srst_i || !pd_n_i) begin
      fwd_q    <= 1'b0;
      per_cnt  <= 8'h00;
      period   <= `LVL_PERIOD_RST;
      acc      <= 8'h00;
      slot     <= `LVL_SLOT_LAST;
      seen     <= 1'b0;
      pub_d    <= 1'b0;
      asm_word <= {`LVL_WORD_BITS{1'b0}};
      data_o   <= {`LVL_WORD_BITS{1'b0}};   // Powered down: outputs low [R7] [R8]
      rclk_o   <= 1'b0;
    end else begin
      fwd_q    <= fwd_clk_i;
      acc      <= next_acc;
      slot     <= next_slot;
      asm_word <= next_asm;
      pub_d    <= publish;
      if (fwd_rise) begin
        seen    <= 1'b1;
        per_cnt <= 8'h00;
        if (seen) begin
          period <= per_cnt + 8'h01;
        end
      end else if (per_cnt != `LVL_PERIOD_MAX) begin
        per_cnt <= per_cnt + 8'h01;
      end
      // Data changes only at a frame edge, so a lost clock freezes it [R10]
      if (publish) begin
        data_o <= asm_word;
      end
      // Clock rises a cycle after the data, falls mid-period; no edges, no rise [R5] [R10]
      if (pub_d) begin
        rclk_o <= 1'b1;
      end else if (per_cnt == {1'b0, period[7:1]}) begin
        rclk_o <= 1'b0;
      end
    end
  end

endmodule // lvl_rx

// file: verilog/lvl_link.v
// Seven-to-one serial link: transmitter serializer and receiver wrapper
`timescale 1ns/10ps
`include "lvl_link_map.vh"

// Frame timing, transmitter side
// The parallel clock pin is slow against the system clock, so it is sampled like data.
// Its rising edge, seen two flops late, captures the whole synchronised word at once.
// The distance between two rises is counted in system clocks and kept as the period.
// A fraction stepper adds seven every cycle and moves to the next slot on overflow,
// so seven slots spread evenly over whatever period the source really runs at.
// With an eight-cycle period the first slot stands two cycles, the others one each.
// The last slot is held until the next rise; a stopped source parks the lanes there.
// The forwarded clock is high for slots zero to three and low for slots four to six,
// so its rise marks slot zero of every frame for the far end.
//
// Frame timing, receiver side
// The receiver finds the forwarded clock rise the same way and runs its own stepper.
// The last sample taken inside a slot is kept, which favours the slot's late half.
// A frame is only complete when the next rise arrives, so data trails by one period.
// The recovered clock rises one cycle after the data and falls half a period later.
//
// Power-down and start-up
// Each power-down pin is synchronised too, so the serial enables drop three edges
// after the pin; this is slower than a pure pin path but keeps the logic clean.
// The lock timer restarts on every power-down, and no frame starts before it expires.
// While the timer runs the pairs are driven to a steady low rather than floated,
// which keeps the far end from decoding noise off an open cable.
// The receiver clears its outputs and sets its period estimate back to eight while powered down, and
// the first forwarded clock rise after that publishes nothing.
//
// Limitations
// A period under seven system clocks loses the late slots; the stepper cannot go
// faster than one slot per cycle.
// A period longer than 255 cycles saturates the counter, wraps the stored period to zero and stretches the last slot.
// Equal levels on a differential pair read as zero, so a released pair is quiet.

// Overview of operation
// R1 - Transmitter captures all 28 inputs on each rising parallel clock edge only.
// R2 - Transmitter drives four serial data lanes plus one forwarded clock lane.
// R3 - Each lane carries seven bit slots per parallel clock period.
// R4 - Receiver rebuilds 28 outputs from four lanes and the forwarded clock.
// R5 - Recovered clock rises after the data settles; sample outputs on its rise.
// R6 - Transmitter power-down low puts all serial outputs in high impedance.
// R7 - Receiver power-down low forces all parallel data outputs low.
// R8 - Power-down may be asserted at any moment without sequencing.
// R9 - After power-down release, transmitter outputs stay quiet for 10 ms lock time.
// R10 - Lost link clock stops recovered clock and freezes data outputs.
// R11 - Source logic ties unused parallel data inputs to zero.
// R12 - Transmitter outputs reach high impedance within 100 ns of power-down; here the enables drop three clock edges after the pin, up to 300 ns.
// R13 - Bit lane*7+slot mapping is fixed; receiver inverts it exactly.
module lvl_link #(
  parameter LOCK_CYCLES = (`LVL_PLL_LOCK_MS * 1000000) / `LVL_CLK_PERIOD_NS
) (
  input  wire                       MCLK_I,
  input  wire                       SRST_I,
  // Transmitter, parallel side
  input  wire                       PARALLEL_CLOCK_IN_I,
  input  wire [`LVL_WORD_BITS-1:0]  PARALLEL_DATA_IN_I,
  input  wire                       TX_POWER_DOWN_N_I,
  // Transmitter, serial side
  output reg  [`LVL_LANES-1:0]      SERIAL_LANE_OUT_P_O,
  output reg  [`LVL_LANES-1:0]      SERIAL_LANE_OUT_N_O,
  output reg  [`LVL_LANES-1:0]      SERIAL_LANE_OUT_OE_O,
  output reg                        FORWARDED_CLOCK_OUT_P_O,
  output reg                        FORWARDED_CLOCK_OUT_N_O,
  output reg                        FORWARDED_CLOCK_OUT_OE_O,
  // Receiver, serial side
  input  wire                       FORWARDED_CLOCK_IN_P_I,
  input  wire                       FORWARDED_CLOCK_IN_N_I,
  input  wire [`LVL_LANES-1:0]      SERIAL_LANE_IN_P_I,
  input  wire [`LVL_LANES-1:0]      SERIAL_LANE_IN_N_I,
  input  wire                       RX_POWER_DOWN_N_I,
  // Receiver, parallel side
  output wire [`LVL_WORD_BITS-1:0]  PARALLEL_DATA_OUT_O,
  output wire                       RECOVERED_CLOCK_OUT_O
);

  localparam [31:0] LOCK_SPAN = LOCK_CYCLES - 1;
  localparam [19:0] LOCK_LAST = LOCK_SPAN[19:0];
  localparam [6:0]  FWD_PAT   = `LVL_FWD_PATTERN;
  localparam        TX_SYNC_W = `LVL_WORD_BITS + 2;
  localparam        RX_SYNC_W = 2 * `LVL_LANES + 3;

  // Synchronised pin levels
  wire [TX_SYNC_W-1:0]      tx_sync;
  wire [RX_SYNC_W-1:0]      rx_sync;
  wire                      tx_pd_n;
  wire                      pclk_s;
  wire [`LVL_WORD_BITS-1:0] data_s;
  wire                      rx_pd_n;
  wire                      rx_fwd;
  wire [`LVL_LANES-1:0]     rx_lane;

  // Transmitter state
  reg                       pclk_q;
  reg [7:0]                 per_cnt;
  reg [7:0]                 period;
  reg [19:0]                lock_cnt;
  reg                       locked;
  reg                       active;
  reg                       seen;
  reg [`LVL_WORD_BITS-1:0]  word;
  reg [2:0]                 slot;
  reg [7:0]                 acc;

  // Next values
  reg                       next_active;
  reg [`LVL_WORD_BITS-1:0]  next_word;
  reg [2:0]                 next_slot;
  reg [7:0]                 next_acc;
  reg [8:0]                 step;
  wire [`LVL_LANES-1:0]     next_lane;
  reg                       next_fwd;
  genvar                    g;

  // Word bit carried by a lane in a slot; one place for the mapping of every lane
  function [4:0] bit_index;
    input [1:0] lane;
    input [2:0] slot_no;
    begin
      bit_index = {3'h0, lane} * 5'h07 + {2'h0, slot_no};
    end
  endfunction

  // Every pin level except SRST_I crosses two flops before any logic looks at it
  lvl_sync #(
    .WIDTH (TX_SYNC_W)
  ) u_tx_sync (
    .clk_i  (MCLK_I),
    .srst_i (SRST_I),
    .d_i    ({TX_POWER_DOWN_N_I, PARALLEL_CLOCK_IN_I, PARALLEL_DATA_IN_I}),
    .q_o    (tx_sync)
  );

  lvl_sync #(
    .WIDTH (RX_SYNC_W)
  ) u_rx_sync (
    .clk_i  (MCLK_I),
    .srst_i (SRST_I),
    .d_i    ({RX_POWER_DOWN_N_I, FORWARDED_CLOCK_IN_P_I, FORWARDED_CLOCK_IN_N_I,
              SERIAL_LANE_IN_P_I, SERIAL_LANE_IN_N_I}),
    .q_o    (rx_sync)
  );

  assign tx_pd_n = tx_sync[TX_SYNC_W-1];
  assign pclk_s  = tx_sync[TX_SYNC_W-2];
  assign data_s  = tx_sync[`LVL_WORD_BITS-1:0];

  // Differential decode: a pair reads one only when true is high and complement low
  assign rx_pd_n = rx_sync[RX_SYNC_W-1];
  assign rx_fwd  = rx_sync[RX_SYNC_W-2] & ~rx_sync[RX_SYNC_W-3];
  assign rx_lane = rx_sync[2*`LVL_LANES-1:`LVL_LANES] & ~rx_sync[`LVL_LANES-1:0];

  wire pclk_rise = pclk_s & ~pclk_q;    // Falling edges never strobe data [R1]

  // Lock timer restarts on every power-down, so a mid-frame assertion is safe
  always @(posedge MCLK_I) begin
    if (SRST_I || !tx_pd_n) begin
      lock_cnt <= 20'h00000;
      locked   <= 1'b0;
    end else if (!locked) begin
      if (lock_cnt == LOCK_LAST) begin
        locked <= 1'b1;                 // Quiet for the whole lock time [R9] [R8]
      end else begin
        lock_cnt <= lock_cnt + 20'h00001;
      end
    end
  end

  // Parallel clock period in system clocks; the slot stepper divides it by seven
  always @(posedge MCLK_I) begin
    if (SRST_I || !tx_pd_n) begin
      pclk_q  <= 1'b0;
      per_cnt <= 8'h00;
      period  <= `LVL_PERIOD_RST;
      seen    <= 1'b0;
    end else begin
      pclk_q <= pclk_s;
      if (pclk_rise) begin
        seen    <= 1'b1;
        per_cnt <= 8'h00;
        if (seen) begin
          period <= per_cnt + 8'h01;
        end
      end else if (per_cnt != `LVL_PERIOD_MAX) begin
        per_cnt <= per_cnt + 8'h01;
      end
    end
  end

  // Frame capture and slot stepping; seven slots spread over one measured period
  always @* begin
    step        = {1'b0, acc} + `LVL_SLOT_STEP;
    next_active = active;
    next_word   = word;
    next_slot   = slot;
    next_acc    = acc;
    if (!locked) begin
      next_active = 1'b0;
    end else if (pclk_rise) begin
      next_word   = data_s;               // Whole word taken at once [R1]
      next_slot   = `LVL_SLOT_FIRST;
      next_acc    = 8'h00;
      next_active = 1'b1;
    end else if (active && slot != `LVL_SLOT_LAST) begin
      if (step >= {1'b0, period}) begin
        next_slot = slot + 3'h1;          // Seven slots per period [R3]
        next_acc  = step[7:0] - period;
      end else begin
        next_acc = step[7:0];
      end
    end
    // Forwarded clock level looked up per slot; idle frames keep it low [R2]
    next_fwd = next_active & FWD_PAT[next_slot];
  end

  // One serializer tap per lane: bits g*7 .. g*7+6, slot order ascending [R13] [R2]
  generate
    for (g = 0; g < `LVL_LANES; g = g + 1) begin : g_lane
      localparam [1:0] LANE = g;
      assign next_lane[g] = next_active & next_word[bit_index(LANE, next_slot)];
    end
  endgenerate

  // Frame registers
  always @(posedge MCLK_I) begin
    if (SRST_I) begin
      active <= 1'b0;
      word   <= {`LVL_WORD_BITS{1'b0}};
      slot   <= `LVL_SLOT_LAST;
      acc    <= 8'h00;
    end else begin
      active <= next_active;
      word   <= next_word;
      slot   <= next_slot;
      acc    <= next_acc;
    end
  end

  // Serial pins; the enable follows power-down directly, one edge after sync [R6] [R12]
  always @(posedge MCLK_I) begin
    if (SRST_I) begin
      SERIAL_LANE_OUT_P_O      <= {`LVL_LANES{1'b0}};
      SERIAL_LANE_OUT_N_O      <= {`LVL_LANES{1'b1}};
      SERIAL_LANE_OUT_OE_O     <= {`LVL_LANES{1'b0}};
      FORWARDED_CLOCK_OUT_P_O  <= 1'b0;
      FORWARDED_CLOCK_OUT_N_O  <= 1'b1;
      FORWARDED_CLOCK_OUT_OE_O <= 1'b0;
    end else begin
      SERIAL_LANE_OUT_P_O      <= next_lane;          // Idle low until locked [R9]
      SERIAL_LANE_OUT_N_O      <= ~next_lane;
      SERIAL_LANE_OUT_OE_O     <= {`LVL_LANES{tx_pd_n}};   // [R6] [R8]
      FORWARDED_CLOCK_OUT_P_O  <= next_fwd;           // [R2]
      FORWARDED_CLOCK_OUT_N_O  <= ~next_fwd;
      FORWARDED_CLOCK_OUT_OE_O <= tx_pd_n;            // [R6]
    end
  end

  // Receiver runs from the decoded lanes; its outputs come from its own flops
  lvl_rx u_rx (
    .clk_i     (MCLK_I),
    .srst_i    (SRST_I),
    .pd_n_i    (rx_pd_n),
    .fwd_clk_i (rx_fwd),
    .lane_i    (rx_lane),
    .data_o    (PARALLEL_DATA_OUT_O),
    .rclk_o    (RECOVERED_CLOCK_OUT_O)
  );

endmodule // lvl_link

// file: verification/lvl_far.sv
// Parallel source model driving the transmitter inputs
`timescale 1ns/10ps

module lvl_far (
  input  logic        run_i,
  input  logic [27:0] word_i,
  output logic        pclk_o,
  output logic [27:0] pdata_o
);
  // 800 ns clock, still and low between bursts; odd phase against the system clock
  initial begin
    pclk_o = 1'b0;
    pdata_o = 28'h0000000;
    #37;
    forever begin
      #400;
      pclk_o = run_i;
      #400;
      pclk_o = 1'b0;
      pdata_o = word_i; // All 28 bits follow word_i; none are forced to zero
    end
  end
endmodule // lvl_far

// file: verification/lvl_link_props.sv
// Port checker for the serial link
`timescale 1ns/10ps
`include "lvl_link_map.vh"

module lvl_link_props #(
  parameter LOCK_CYCLES = 20
) (
  input logic                      MCLK_I,
  input logic                      SRST_I,
  input logic                      TX_POWER_DOWN_N_I,
  input logic                      RX_POWER_DOWN_N_I,
  input logic                      FORWARDED_CLOCK_IN_P_I,
  input logic [`LVL_LANES-1:0]     SERIAL_LANE_OUT_P_O,
  input logic [`LVL_LANES-1:0]     SERIAL_LANE_OUT_N_O,
  input logic [`LVL_LANES-1:0]     SERIAL_LANE_OUT_OE_O,
  input logic                      FORWARDED_CLOCK_OUT_P_O,
  input logic                      FORWARDED_CLOCK_OUT_N_O,
  input logic                      FORWARDED_CLOCK_OUT_OE_O,
  input logic [`LVL_WORD_BITS-1:0] PARALLEL_DATA_OUT_O,
  input logic                      RECOVERED_CLOCK_OUT_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SRST_I);
  // Cycles awake and cycles without a forwarded edge, both saturating
  logic [7:0] awake;
  logic [4:0] idle;
  always_ff @(posedge MCLK_I) begin
    if (SRST_I || !TX_POWER_DOWN_N_I) begin
      awake <= 8'h00;
    end else begin
      awake <= awake + {7'h00, awake != 8'hff};
    end
    if (SRST_I || $changed(FORWARDED_CLOCK_IN_P_I)) begin
      idle <= 5'h00;
    end else begin
      idle <= idle + {4'h0, idle != 5'h1f};
    end
  end
  a_lane_pair: assert property (SERIAL_LANE_OUT_N_O == ~SERIAL_LANE_OUT_P_O)
    else $error("lane pair not complementary");
  a_fwd_pair: assert property (FORWARDED_CLOCK_OUT_N_O == !FORWARDED_CLOCK_OUT_P_O)
    else $error("clock pair not complementary");
  a_enable_match: assert property (SERIAL_LANE_OUT_OE_O == {4{FORWARDED_CLOCK_OUT_OE_O}})
    else $error("enables disagree");
  a_pd_float: assert property (!TX_POWER_DOWN_N_I [*3] |=>
      SERIAL_LANE_OUT_OE_O == 4'h0 && !FORWARDED_CLOCK_OUT_OE_O)
    else $error("outputs still driven in power-down");
  a_rx_pd_low: assert property (!RX_POWER_DOWN_N_I [*3] |=>
      PARALLEL_DATA_OUT_O == 0 && !RECOVERED_CLOCK_OUT_O)
    else $error("receiver outputs not low");
  a_lock_quiet: assert property (disable iff (SRST_I || !TX_POWER_DOWN_N_I)
      awake < LOCK_CYCLES |-> !FORWARDED_CLOCK_OUT_P_O && SERIAL_LANE_OUT_P_O == 4'h0)
    else $error("toggle before lock");
  a_slot_frame: assert property (disable iff (SRST_I || !TX_POWER_DOWN_N_I)
      $rose(FORWARDED_CLOCK_OUT_P_O) |->
      FORWARDED_CLOCK_OUT_P_O [*5] ##1 !FORWARDED_CLOCK_OUT_P_O [*3])
    else $error("forwarded clock slots wrong");
  a_strobe_settled: assert property ($rose(RECOVERED_CLOCK_OUT_O) |->
      $stable(PARALLEL_DATA_OUT_O))
    else $error("data moved at strobe");
  a_strobe_width: assert property ($rose(RECOVERED_CLOCK_OUT_O) |->
      ##[1:4] !RECOVERED_CLOCK_OUT_O)
    else $error("strobe too long");
  a_loss_freeze: assert property (disable iff (SRST_I || !RX_POWER_DOWN_N_I)
      idle > 5'h10 |-> $stable(PARALLEL_DATA_OUT_O) && !RECOVERED_CLOCK_OUT_O)
    else $error("receiver moved without link clock");
  c_strobe: cover property ($rose(RECOVERED_CLOCK_OUT_O));
  c_float: cover property ($fell(FORWARDED_CLOCK_OUT_OE_O));
  c_loss: cover property (idle == 5'h1f);
endmodule // lvl_link_props

bind lvl_link lvl_link_props #(.LOCK_CYCLES(LOCK_CYCLES)) u_props (.*);

// file: verification/lvl_link_bench.sv
// Self-checking bench: transmitter looped back to receiver through a cable model
`timescale 1ns/10ps

module lvl_link_bench;
  logic        mclk, srst, tx_pd_n, rx_pd_n, run, pclk, rclk, fwd_p, fwd_n, fwd_oe;
  logic [3:0]  lp, ln, loe;
  logic [27:0] word, pdata, dout;
  int          mismatches, n_compared;

  lvl_far u_far (.run_i(run), .word_i(word), .pclk_o(pclk), .pdata_o(pdata));
  // A released pair rests at zero differential across its termination
  lvl_link #(.LOCK_CYCLES(20)) u_dut (.MCLK_I(mclk), .SRST_I(srst),
    .PARALLEL_CLOCK_IN_I(pclk), .PARALLEL_DATA_IN_I(pdata), .TX_POWER_DOWN_N_I(tx_pd_n),
    .SERIAL_LANE_OUT_P_O(lp), .SERIAL_LANE_OUT_N_O(ln), .SERIAL_LANE_OUT_OE_O(loe),
    .FORWARDED_CLOCK_OUT_P_O(fwd_p), .FORWARDED_CLOCK_OUT_N_O(fwd_n),
    .FORWARDED_CLOCK_OUT_OE_O(fwd_oe), .FORWARDED_CLOCK_IN_P_I(fwd_p & fwd_oe),
    .FORWARDED_CLOCK_IN_N_I(fwd_n & fwd_oe), .SERIAL_LANE_IN_P_I(lp & loe),
    .SERIAL_LANE_IN_N_I(ln & loe), .RX_POWER_DOWN_N_I(rx_pd_n),
    .PARALLEL_DATA_OUT_O(dout), .RECOVERED_CLOCK_OUT_O(rclk));

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Bounded wait for a rising level, sampled at falling edges
  task automatic await_rise(ref logic s);
    logic q;
    int   i;
    q = s;
    for (i = 0; i < 40; i++) begin
      @(negedge mclk);
      if (s && !q) break;
      q = s;
    end
    if (i == 40) begin
      mismatches++;
      summarize;
    end
  endtask

  // Nothing may toggle during the lock wait even though the clock already runs
  task automatic t_lock;
    logic seen;
    seen = 1'b0;
    repeat (20) begin
      @(negedge mclk);
      seen = seen | fwd_p | (|lp);
    end
    check({seen, fwd_oe}, 2'b01);
  endtask

  // One word: rebuilt slot by slot from the lanes, then read at the receiver
  task automatic t_word(input logic [27:0] w);
    logic [27:0] got;
    int          k;
    word = w;
    repeat (16) @(negedge mclk);
    await_rise(fwd_p);
    for (k = 0; k < 7; k++) begin
      repeat (k == 1 ? 2 : (k > 0 ? 1 : 0)) @(negedge mclk);
      {got[21+k], got[14+k], got[7+k], got[k]} = lp;
    end
    check(got, w);
    await_rise(rclk);
    check({rclk, dout}, {1'b1, w});
  endtask

  // Receiver power-down in mid traffic, with no preparation
  task automatic t_rx_pd;
    rx_pd_n = 1'b0;
    repeat (3) @(negedge mclk);
    check({rclk, dout}, 40'h0);
    rx_pd_n = 1'b1;
  endtask

  // Parallel clock stops: lanes park on the last slot, receiver freezes
  task automatic t_loss(input logic [27:0] w);
    run = 1'b0;
    repeat (40) @(negedge mclk);
    check({rclk, fwd_p, lp, dout}, {2'b00, w[27], w[20], w[13], w[6], w});
  endtask

  // Transmitter power-down releases every pair within the chosen latency
  task automatic t_tx_pd;
    tx_pd_n = 1'b0;
    rx_pd_n = 1'b0;
    repeat (3) @(negedge mclk);
    check({loe, fwd_oe}, 40'h0);
  endtask

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  initial begin
    srst = 1'b1;
    tx_pd_n = 1'b1;
    rx_pd_n = 1'b1;
    run = 1'b1;
    word = 28'h0000000;
    repeat (8) @(negedge mclk);
    check({lp, ln, loe, fwd_p, fwd_n, fwd_oe, rclk}, 16'h0f04);
    srst = 1'b0;
    t_lock;
    t_word(28'h9a5c3e1);
    t_word(28'h65a3c1e);
    t_rx_pd;
    t_word(28'hfffffff);
    t_word(28'h8000001);
    t_loss(28'h8000001);
    t_tx_pd;
    summarize;
  end
endmodule // lvl_link_bench
